// file: verilog/pcc_front_end.v
// parallel camera capture front end: sync decode, routing, buffer
`timescale 1ns/1ps
`default_nettype none
`include "pcc_regs.vh"

module pcc_front_end #(
   parameter AW = `PCC_LINE_AW,
   parameter CW = `PCC_FRM_CW
) (
   // clock and reset
   input  wire          ref_clk,
   input  wire          rst,
   // sensor pins
   input  wire          pix_clk,
   input  wire [9:0]    pix_data,
   input  wire          href,
   input  wire          vsync,
   // static configuration
   input  wire          cfg_enable,
   input  wire          cfg_bt656,
   input  wire [1:0]    cfg_in_fmt,
   input  wire [1:0]    cfg_out_mode,
   input  wire [1:0]    cfg_chans,
   input  wire          cfg_weave,
   // queue stream
   output reg           q_valid,
   output reg  [7:0]    q_data,
   output reg  [1:0]    q_chan,
   output reg  [1:0]    q_queue,
   output reg           q_last,
   output reg  [11:0]   q_line,
   output reg           q_field,
   // status
   output reg           buf_bank,
   output reg           frame_tick,
   output reg  [CW-1:0] frame_cycles,
   output reg           hdr_err,
   output reg           line_drop
);

   localparam LW = `PCC_LINE_W;
   // header search states, one-hot
   localparam ST_IDLE = 4'b0001;
   localparam ST_ONE  = 4'b0010;
   localparam ST_Z1   = 4'b0100;
   localparam ST_Z2   = 4'b1000;
   // drain states, one-hot
   localparam DR_IDLE = 2'b01;
   localparam DR_RUN  = 2'b10;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   reg [7:0] d_s1, d_s2;
   reg       pclk_s1, pclk_s2, pclk_s3;
   reg       href_s1, href_s2;
   reg       vs_s1, vs_s2, vs_s3;

   // only the upper eight lines are taken in
   always @(posedge ref_clk) begin
      if (rst) begin
         d_s1    <= 8'h00;
         d_s2    <= 8'h00;
         pclk_s1 <= 1'b0;
         pclk_s2 <= 1'b0;
         pclk_s3 <= 1'b0;
         href_s1 <= 1'b0;
         href_s2 <= 1'b0;
         vs_s1   <= 1'b0;
         vs_s2   <= 1'b0;
         vs_s3   <= 1'b0;
      end else begin
         d_s1    <= pix_data[9:2];
         d_s2    <= d_s1;
         pclk_s1 <= pix_clk;
         pclk_s2 <= pclk_s1;
         pclk_s3 <= pclk_s2;
         href_s1 <= href;
         href_s2 <= href_s1;
         vs_s1   <= vsync;
         vs_s2   <= vs_s1;
         vs_s3   <= vs_s2;
      end
   end

   wire pclk_rise = pclk_s2 & ~pclk_s3;
   wire vs_rise   = vs_s2 & ~vs_s3;

   // ----------------------------------------------------------------
   // word capture and channel slot
   // ----------------------------------------------------------------
   reg       w_v;
   reg [7:0] w;
   reg       w_href;
   reg [1:0] w_slot;
   reg [1:0] slot;
   wire [1:0] slot_last = (cfg_chans == `PCC_CHANS_4) ? 2'h3 :
                          (cfg_chans == `PCC_CHANS_2) ? 2'h1 : 2'h0;

   // one word per rising pixel clock edge
   always @(posedge ref_clk) begin
      if (rst || !cfg_enable) begin
         w_v    <= 1'b0;
         w      <= 8'h00;
         w_href <= 1'b0;
         w_slot <= 2'h0;
         slot   <= 2'h0;
      end else begin
         w_v <= pclk_rise;
         if (pclk_rise) begin
            w      <= d_s2;
            w_href <= href_s2;
            w_slot <= slot;
            // words of the multiplexed channels take turns
            if (!cfg_bt656 || slot == slot_last) begin
               slot <= 2'h0;
            end else begin
               slot <= slot + 2'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // per-channel and shared decoder state
   // ----------------------------------------------------------------
   reg [3:0]    hdr_st [0:3];
   reg [1:0]    ph     [0:3];
   reg [3:0]    act, fld, vbl, lodd, pxo;
   reg [LW-1:0] line_no, cur_line;
   reg          fstart;
   reg          wr_en_q;
   reg [11:0]   wr_data_q;

   // ----------------------------------------------------------------
   // header search, code check and component routing
   // ----------------------------------------------------------------
   reg [3:0] cur, nxt_st;
   reg       is_stat, code_ok, is_data, keep;
   reg [1:0] p, q, ch;
   reg [3:0] pexp;

   always @* begin
      cur    = hdr_st[w_slot];
      p      = ph[w_slot];
      nxt_st = ST_IDLE;
      case (cur)
         ST_IDLE: begin
            if (w == `PCC_SYNC_ONES) nxt_st = ST_ONE;
         end
         ST_ONE, ST_Z1: begin
            if (w == `PCC_SYNC_ZERO) begin
               nxt_st = (cur == ST_ONE) ? ST_Z1 : ST_Z2;
            end else if (w == `PCC_SYNC_ONES) begin
               nxt_st = ST_ONE;
            end
         end
         ST_Z2:   nxt_st = ST_IDLE;
         default: nxt_st = ST_IDLE;
      endcase
      is_stat = cfg_bt656 && (cur == ST_Z2);
      // protection bits follow from F, V and H
      pexp[3] = w[`PCC_BIT_VBL] ^ w[`PCC_BIT_SEL];
      pexp[2] = w[`PCC_BIT_FLD] ^ w[`PCC_BIT_SEL];
      pexp[1] = w[`PCC_BIT_FLD] ^ w[`PCC_BIT_VBL];
      pexp[0] = pexp[1] ^ w[`PCC_BIT_SEL];
      code_ok = w[`PCC_BIT_ONE] && (w[3:0] == pexp);
      // header words are held back from the picture
      if (cfg_bt656) begin
         is_data = act[w_slot] && nxt_st == ST_IDLE && cur != ST_Z2;
      end else begin
         is_data = w_href;
      end
      keep = 1'b1;
      ch   = w_slot;
      q    = `PCC_QUEUE_ZERO;
      if (cfg_out_mode == `PCC_OUT_RAW) begin
         ch = 2'h0;
      end else if (cfg_in_fmt == `PCC_IN_RAW) begin
         // Y, U, V bytes of a 4:4:4 pixel
         if (p == 2'h0) begin
            ch = 2'h0;
         end else if (cfg_out_mode == `PCC_OUT_PLANAR) begin
            ch = p;
         end else begin
            ch   = 2'h1;
            keep = ~pxo[w_slot];
         end
      end else begin
         // Y U Y V order; chroma only on colour lines for 4:2:0
         if (p[0]) begin
            keep = !(cfg_in_fmt == `PCC_IN_YUV420 && lodd[w_slot]);
            q = (cfg_out_mode == `PCC_OUT_PLANAR && p[1]) ?
                `PCC_QUEUE_TWO : `PCC_QUEUE_ONE;
         end
      end
   end

   // ----------------------------------------------------------------
   // decoder state update
   // ----------------------------------------------------------------
   integer i;

   always @(posedge ref_clk) begin
      if (rst || !cfg_enable) begin
         for (i = 0; i < 4; i = i + 1) begin
            hdr_st[i] <= ST_IDLE;
            ph[i]     <= 2'h0;
         end
         act       <= 4'h0;
         fld       <= 4'h0;
         vbl       <= 4'h0;
         lodd      <= 4'h0;
         pxo       <= 4'h0;
         line_no   <= {LW{1'b0}};
         cur_line  <= {LW{1'b0}};
         fstart    <= 1'b0;
         wr_en_q   <= 1'b0;
         wr_data_q <= 12'h000;
         hdr_err   <= 1'b0;
      end else begin
         fstart  <= 1'b0;
         hdr_err <= 1'b0;
         wr_en_q <= w_v && is_data && keep;
         wr_data_q <= {ch, q, w};
         // sensor mode: frame begins on the vsync edge
         if (!cfg_bt656 && vs_rise) begin
            fstart  <= 1'b1;
            line_no <= {LW{1'b0}};
            lodd[0] <= 1'b0;
            fld[0]  <= 1'b0;
         end
         if (w_v && is_data) begin
            // component phase and pixel parity
            if (cfg_in_fmt == `PCC_IN_RAW && p == 2'h2) begin
               ph[w_slot]  <= 2'h0;
               pxo[w_slot] <= ~pxo[w_slot];
            end else begin
               ph[w_slot] <= p + 2'h1;
            end
         end
         // sensor mode: line valid alone frames the line, so a pixel
         // clock that stops after the last word still ends it
         if (!cfg_bt656) begin
            act[0] <= href_s2;
            if (!href_s2) begin
               ph[0]  <= 2'h0;
               pxo[0] <= 1'b0;
            end
            if (href_s2 && !act[0]) begin
               cur_line <= line_no;
               line_no  <= line_no + 1'b1;
            end
            if (!href_s2 && act[0]) begin
               lodd[0] <= ~lodd[0];
            end
         end
         if (w_v && cfg_bt656) begin
            hdr_st[w_slot] <= nxt_st;
            if (is_stat && !code_ok) begin
               hdr_err <= 1'b1;
            end else if (is_stat && !w[`PCC_BIT_SEL]) begin
               // start code: active only outside blanking
               act[w_slot] <= ~w[`PCC_BIT_VBL];
               fld[w_slot] <= w[`PCC_BIT_FLD];
               vbl[w_slot] <= w[`PCC_BIT_VBL];
               ph[w_slot]  <= 2'h0;
               pxo[w_slot] <= 1'b0;
               if (!w[`PCC_BIT_VBL] && vbl[w_slot]) begin
                  lodd[w_slot] <= 1'b0;
               end
               if (w_slot == 2'h0 && !w[`PCC_BIT_VBL]) begin
                  if (vbl[0]) begin
                     cur_line <= {LW{1'b0}};
                     line_no  <= {{(LW-1){1'b0}}, 1'b1};
                     fstart   <= ~w[`PCC_BIT_FLD];
                  end else begin
                     cur_line <= line_no;
                     line_no  <= line_no + 1'b1;
                  end
               end
            end else if (is_stat) begin
               // end code closes the line
               act[w_slot] <= 1'b0;
               vbl[w_slot] <= w[`PCC_BIT_VBL];
               if (act[w_slot]) begin
                  lodd[w_slot] <= ~lodd[w_slot];
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // frame rate statistic
   // ----------------------------------------------------------------
   reg [CW-1:0] cyc;

   // cycles from one frame start to the next
   always @(posedge ref_clk) begin
      if (rst) begin
         cyc          <= {CW{1'b0}};
         frame_cycles <= {CW{1'b0}};
         frame_tick   <= 1'b0;
      end else begin
         frame_tick <= fstart;
         if (fstart) begin
            frame_cycles <= cyc;
            cyc          <= {{(CW-1){1'b0}}, 1'b1};
         end else if (~&cyc) begin
            cyc <= cyc + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // double-buffered line store
   // ----------------------------------------------------------------
   reg [AW-1:0] wr_ptr, rd_ptr, drain_len;
   reg [1:0]    dr_st;
   reg          act_any_d, rd_en, rd_v, rd_last, rd_last_d;
   reg [LW:0]   lat_line;
   reg          lat_field;
   wire [11:0]  rd_data;
   wire         act_any  = |act;
   wire         line_end = act_any_d & ~act_any;
   wire         wr_ok    = wr_en_q & ~(&wr_ptr);
   wire [AW-1:0] wr_cnt  = wr_ptr + {{(AW-1){1'b0}}, wr_ok};

   // a finished line swaps banks only when the drain is idle;
   // the drain runs at the system clock, far above the word rate
   always @(posedge ref_clk) begin
      if (rst || !cfg_enable) begin
         wr_ptr    <= {AW{1'b0}};
         rd_ptr    <= {AW{1'b0}};
         drain_len <= {AW{1'b0}};
         dr_st     <= DR_IDLE;
         buf_bank  <= 1'b0;
         act_any_d <= 1'b0;
         rd_en     <= 1'b0;
         rd_last   <= 1'b0;
         lat_line  <= {(LW+1){1'b0}};
         lat_field <= 1'b0;
         line_drop <= 1'b0;
      end else begin
         act_any_d <= act_any;
         line_drop <= 1'b0;
         rd_en     <= 1'b0;
         rd_last   <= 1'b0;
         if (line_end && wr_cnt != {AW{1'b0}}) begin
            wr_ptr <= {AW{1'b0}};
            if (dr_st == DR_IDLE) begin
               buf_bank  <= ~buf_bank;
               drain_len <= wr_cnt;
               rd_ptr    <= {AW{1'b0}};
               dr_st     <= DR_RUN;
               lat_field <= fld[0];
               lat_line  <= cfg_weave ? {cur_line, fld[0]} :
                                        {1'b0, cur_line};
            end else begin
               line_drop <= 1'b1;
            end
         end else if (wr_ok) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         case (dr_st)
            // a swap above starts the drain; idle must not undo it
            DR_IDLE: rd_en <= 1'b0;
            DR_RUN: begin
               rd_en   <= 1'b1;
               rd_last <= (rd_ptr + 1'b1 == drain_len);
               rd_ptr  <= rd_ptr + 1'b1;
               if (rd_ptr + 1'b1 == drain_len) begin
                  dr_st <= DR_IDLE;
               end
            end
            default: dr_st <= DR_IDLE;
         endcase
      end
   end

   pcc_line_mem #(
      .DW (12),
      .AW (AW)
   ) u_mem (
      .clk     (ref_clk),
      .wr_en   (wr_ok),
      .wr_addr ({buf_bank, wr_ptr}),
      .wr_data (wr_data_q),
      .rd_en   (rd_en),
      .rd_addr ({~buf_bank, rd_ptr - 1'b1}),
      .rd_data (rd_data)
   );

   // ----------------------------------------------------------------
   // queue stream outputs
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (rst) begin
         rd_v      <= 1'b0;
         rd_last_d <= 1'b0;
         q_valid   <= 1'b0;
         q_data    <= 8'h00;
         q_chan    <= 2'h0;
         q_queue   <= 2'h0;
         q_last    <= 1'b0;
         q_line    <= 12'h000;
         q_field   <= 1'b0;
      end else begin
         rd_v      <= rd_en;
         rd_last_d <= rd_last;
         q_valid   <= rd_v;
         q_last    <= rd_v & rd_last_d;
         if (rd_v) begin
            q_data  <= rd_data[7:0];
            q_queue <= rd_data[9:8];
            q_chan  <= rd_data[11:10];
            q_line  <= lat_line;
            q_field <= lat_field;
         end
      end
   end

endmodule // pcc_front_end

`default_nettype wire

// file: shared/pcc_regs.vh
// constants of the parallel camera capture front end
`ifndef PCC_REGS_VH
`define PCC_REGS_VH

// ----------------------------------------------------------------
// timing reference words (upper eight data lines)
// ----------------------------------------------------------------
`define PCC_SYNC_ONES   8'hFF
`define PCC_SYNC_ZERO   8'h00
`define PCC_BIT_ONE     7
`define PCC_BIT_FLD     6
`define PCC_BIT_VBL     5
`define PCC_BIT_SEL     4

// ----------------------------------------------------------------
// configuration encodings
// ----------------------------------------------------------------
`define PCC_IN_YUV422   2'h0
`define PCC_IN_YUV420   2'h1
`define PCC_IN_RAW      2'h2
`define PCC_OUT_PLANAR  2'h0
`define PCC_OUT_COMB    2'h1
`define PCC_OUT_RAW     2'h2
`define PCC_CHANS_1     2'h0
`define PCC_CHANS_2     2'h1
`define PCC_CHANS_4     2'h2

// ----------------------------------------------------------------
// queue tags {channel, queue}
// ----------------------------------------------------------------
`define PCC_QUEUE_ZERO          2'h0
`define PCC_QUEUE_ONE           2'h1
`define PCC_QUEUE_TWO           2'h2
`define PCC_CHAN_ZERO_QUEUE_ZERO  4'h0
`define PCC_CHAN_ZERO_QUEUE_ONE   4'h1
`define PCC_CHAN_ZERO_QUEUE_TWO   4'h2
`define PCC_CHAN_ONE_QUEUE_ZERO   4'h4
`define PCC_CHAN_TWO_QUEUE_ZERO   4'h8
`define PCC_CHAN_THREE_QUEUE_ZERO 4'hC

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PCC_LINE_AW     12
`define PCC_FRM_CW      32
`define PCC_LINE_W      11

`endif

// file: verilog/pcc_line_mem.v
// two-bank line memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module pcc_line_mem #(
   parameter DW = 12,
   parameter AW = 12
) (
   // clock
   input  wire          clk,
   // write side
   input  wire          wr_en,
   input  wire [AW:0]   wr_addr,
   input  wire [DW-1:0] wr_data,
   // read side
   input  wire          rd_en,
   input  wire [AW:0]   rd_addr,
   output reg  [DW-1:0] rd_data
);

   // top address bit selects the bank
   reg [DW-1:0] mem [0:(2<<AW)-1];

   // ----------------------------------------------------------------
   // write port
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // ----------------------------------------------------------------
   // read port, data one cycle after the enable
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule // pcc_line_mem

`default_nettype wire

// file: test/pcc_cam_model.sv
// behavioural camera source for the capture front end
`timescale 1ns/1ps
`default_nettype none

module pcc_cam_model (
   // sensor pins
   output logic       pix_clk,
   output logic [9:0] pix_data,
   output logic       href,
   output logic       vsync
);
   // pixel clock stands low outside frames
   initial begin
      pix_clk = 1'b0;
      pix_data = 10'h155;
      href = 1'b0;
      vsync = 1'b0;
   end

   // one word; low pair is junk a receiver must not read
   task automatic word(input logic [7:0] b);
      pix_data = {b, 2'h2};
      #62.5 pix_clk = 1'b1;
      #62.5 pix_clk = 1'b0;
   endtask

   // timing reference; e spoils protection on purpose
   task automatic code(input logic f, v, h, e);
      logic [3:0] p;
      p = {v ^ h, f ^ h, f ^ v, f ^ v ^ h} ^ {3'h0, e};
      word(8'hFF);
      word(8'h00);
      word(8'h00);
      word({1'b1, f, v, h, p});
   endtask

   // released bus shows no stale value
   task automatic idle(input int n);
      pix_data = ~pix_data;
      #(125.0 * n);
   endtask

   // sensor mode line framed by line valid
   task automatic sline(input logic [31:0] w);
      href = 1'b1;
      for (int i = 0; i < 4; i++)
         word(w[31-8*i -: 8]);
      href = 1'b0;
      idle(4);
   endtask

   // sensor mode frame start
   task automatic vpulse();
      vsync = 1'b1;
      idle(2);
      vsync = 1'b0;
      idle(2);
   endtask
endmodule // pcc_cam_model

`default_nettype wire

// file: test/pcc_front_end_props.sv
// assertions on the capture front end ports
`timescale 1ns/1ps
`default_nettype none

module pcc_front_end_chk #(
   parameter CW = 32
) (
   // clock and reset
   input wire logic          ref_clk,
   input wire logic          rst,
   // configuration
   input wire logic          cfg_bt656,
   input wire logic [1:0]    cfg_in_fmt,
   input wire logic [1:0]    cfg_out_mode,
   input wire logic [1:0]    cfg_chans,
   // stream and status
   input wire logic          q_valid,
   input wire logic [1:0]    q_chan,
   input wire logic [1:0]    q_queue,
   input wire logic          q_last,
   input wire logic          buf_bank,
   input wire logic          frame_tick,
   input wire logic [CW-1:0] frame_cycles,
   input wire logic          hdr_err
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_last_in_word: assert property (q_last |-> q_valid)
      else $error("last flag without a word");
   a_queue_range: assert property (q_valid |-> q_queue != 2'h3)
      else $error("queue out of range");
   a_comb_two_q: assert property (
      q_valid && cfg_out_mode == 2'h1 && cfg_in_fmt == 2'h0
      |-> q_queue != 2'h2) else $error("combined word in queue two");
   a_raw_one_q: assert property (
      q_valid && cfg_out_mode == 2'h2 |-> q_chan == 2'h0 && q_queue == 2'h0)
      else $error("raw word off queue zero");
   a_one_chan: assert property (
      q_valid && cfg_bt656 && cfg_chans == 2'h0 && cfg_in_fmt != 2'h2
      |-> q_chan == 2'h0) else $error("word on absent channel");
   a_tick_pulse: assert property (frame_tick |=> !frame_tick)
      else $error("frame tick longer than a cycle");
   a_count_on_tick: assert property (
      $changed(frame_cycles) |-> frame_tick)
      else $error("frame count moved off tick");
   // drain starts three cycles after the bank swap
   a_bank_then_drain: assert property (
      $rose(q_valid) |-> $past(buf_bank, 3) != $past(buf_bank, 4))
      else $error("drain without bank swap");
   a_hdr_pulse: assert property (hdr_err |=> !hdr_err)
      else $error("header error longer than a cycle");
endmodule // pcc_front_end_chk

bind pcc_front_end pcc_front_end_chk #(.CW(CW)) u_chk (
   .ref_clk(ref_clk), .rst(rst), .cfg_bt656(cfg_bt656),
   .cfg_in_fmt(cfg_in_fmt), .cfg_out_mode(cfg_out_mode),
   .cfg_chans(cfg_chans), .q_valid(q_valid), .q_chan(q_chan),
   .q_queue(q_queue), .q_last(q_last), .buf_bank(buf_bank),
   .frame_tick(frame_tick), .frame_cycles(frame_cycles),
   .hdr_err(hdr_err));

`default_nettype wire

// file: test/pcc_front_end_tb.sv
// self-checking bench of the capture front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
   err_count++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); \
   end end

module pcc_front_end_tb;
   logic        ref_clk, rst, cfg_enable, cfg_bt656, cfg_weave;
   logic [1:0]  cfg_in_fmt, cfg_out_mode, cfg_chans;
   wire logic   pix_clk, href, vsync;
   wire logic [9:0] pix_data;
   logic        q_valid, q_last, q_field, frame_tick, hdr_err, line_drop;
   logic [7:0]  q_data;
   logic [1:0]  q_chan, q_queue;
   logic [11:0] q_line, ln_seen;
   logic [31:0] frame_cycles, fc_seen;
   logic [13:0] got[$];
   int          err_count, n_compared, ticks, errs, cyc, tk0, tk1, drops;

   pcc_front_end #(.AW(6)) u_pcc_front_end (
      .ref_clk(ref_clk), .rst(rst), .pix_clk(pix_clk),
      .pix_data(pix_data), .href(href), .vsync(vsync),
      .cfg_enable(cfg_enable), .cfg_bt656(cfg_bt656),
      .cfg_in_fmt(cfg_in_fmt), .cfg_out_mode(cfg_out_mode),
      .cfg_chans(cfg_chans), .cfg_weave(cfg_weave),
      .q_valid(q_valid), .q_data(q_data), .q_chan(q_chan),
      .q_queue(q_queue), .q_last(q_last), .q_line(q_line),
      .q_field(q_field), .buf_bank(), .frame_tick(frame_tick),
      .frame_cycles(frame_cycles), .hdr_err(hdr_err),
      .line_drop(line_drop));

   pcc_cam_model u_cam (.pix_clk(pix_clk), .pix_data(pix_data),
      .href(href), .vsync(vsync));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // stream and status collector
   always @(posedge ref_clk) begin
      cyc++;
      if (q_valid === 1'b1) begin
         got.push_back({q_field, q_last, q_chan, q_queue, q_data});
         ln_seen = q_line;
      end
      if (line_drop === 1'b1)
         drops++;
      if (frame_tick === 1'b1) begin
         ticks++;
         tk0 = tk1;
         tk1 = cyc;
         fc_seen = frame_cycles;
      end
      if (hdr_err === 1'b1)
         errs++;
   end

   task automatic stop_test();
      if (err_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // embedded-code line: start code, four words, end code
   task automatic bt_line(input logic f, v, input logic [31:0] w);
      u_cam.code(f, v, 1'b0, 1'b0);
      for (int i = 0; i < 4; i++)
         u_cam.word(w[31-8*i -: 8]);
      u_cam.code(f, v, 1'b1, 1'b0);
      u_cam.idle(4);
   endtask

   // qs packs the expected {channel, queue} of each word, four bits apiece
   task automatic chk4(input logic [15:0] qs, input logic [31:0] w,
                       input logic f);
      for (int i = 0; i < 200 && got.size() < 4; i++)
         @(posedge ref_clk);
      `CHK(got.size(), 4)
      for (int k = 0; k < 4; k++)
         `CHK(got[k], {f, k == 3, qs[15-4*k -: 4], w[31-8*k -: 8]})
      got.delete();
   endtask

   task automatic set_mode(input logic bt, input logic [1:0] m);
      @(posedge ref_clk);
      cfg_bt656 <= bt;
      cfg_out_mode <= m;
   endtask

   // blanking hidden; fake end code inside data stays data
   task automatic t_planar();
      bt_line(1'b0, 1'b1, 32'h11223344);
      `CHK(got.size(), 0)
      bt_line(1'b0, 1'b0, 32'h8000009D);
      chk4(16'h0102, 32'h8000009D, 1'b0);
      `CHK(ticks, 1)
   endtask

   // spoiled protection flagged, decoder state kept
   task automatic t_hdr();
      u_cam.code(1'b0, 1'b0, 1'b1, 1'b1);
      u_cam.idle(4);
      `CHK(errs, 1)
      set_mode(1'b1, 2'h1);
      bt_line(1'b0, 1'b0, 32'h10203040);
      chk4(16'h0101, 32'h10203040, 1'b0);
   endtask

   // raw output, second field woven, then 4:4:4 raw input
   task automatic t_raw_field();
      set_mode(1'b1, 2'h2);
      bt_line(1'b0, 1'b0, 32'h5A6B7C8D);
      chk4(16'h0000, 32'h5A6B7C8D, 1'b0);
      set_mode(1'b1, 2'h0);
      cfg_weave <= 1'b1;
      bt_line(1'b1, 1'b0, 32'hC1C2C3C4);
      chk4(16'h0102, 32'hC1C2C3C4, 1'b1);
      `CHK(ln_seen, 12'h007)
      @(posedge ref_clk);
      cfg_in_fmt <= 2'h2;
      bt_line(1'b1, 1'b0, 32'h0A0B0C0D);
      chk4(16'h0480, 32'h0A0B0C0D, 1'b1);
   endtask

   // sensor pins with line valid and frame sync, then an odd 4:2:0 line
   task automatic t_sensor();
      set_mode(1'b0, 2'h0);
      cfg_in_fmt <= 2'h0;
      u_cam.vpulse();
      u_cam.sline(32'hA1B2C3D4);
      chk4(16'h0102, 32'hA1B2C3D4, 1'b0);
      `CHK(ticks, 2)
      `CHK(fc_seen, 32'(tk1 - tk0))
      @(posedge ref_clk);
      cfg_in_fmt <= 2'h1;
      u_cam.sline(32'hE1E2E3E4);
      `CHK(got.size(), 2)
      `CHK(got[1], {2'h1, 4'h0, 8'hE3})
      `CHK(drops, 0)
      got.delete();
   endtask

   initial begin
      rst = 1'b1;
      cfg_enable = 1'b1;
      cfg_bt656 = 1'b1;
      cfg_weave = 1'b0;
      cfg_in_fmt = 2'h0;
      cfg_out_mode = 2'h0;
      cfg_chans = 2'h0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      t_planar();
      t_hdr();
      t_raw_field();
      t_sensor();
      stop_test();
   end

   // hang guard, far beyond the few lines sent
   initial begin
      #300000;
      err_count++;
      stop_test();
   end
endmodule // pcc_front_end_tb

`default_nettype wire
